// file: src/disp_timing_consts.svh
// Offsets, field positions, reset values and codes of the timing setup block.
// Overview of operation
// - B3 low nibble sets divide, reset zero
// - Divide codes select powers of two
// - B3 high nibble sets oscillator level, reset 0101
// - B4 first parameter selects segment-low voltage
// - B4 second parameter bits 7:3 select enhancement
// - B5 bits 1:0 configure general pin zero
// - B5 bits 3:2 configure general pin one
// - B6 low nibble sets second pre-charge clocks
`ifndef DISP_TIMING_CONSTS_SVH
`define DISP_TIMING_CONSTS_SVH

`define OFF_COMMAND 8'h00
`define OFF_PARAMETER 8'h04
`define OFF_SETTINGS 8'h08
`define OFF_PINS 8'h0C

`define OP_CLOCK_SETUP 8'hB3
`define OP_SEGMENT_ENHANCE 8'hB4
`define OP_PIN_SETUP 8'hB5
`define OP_PRECHARGE 8'hB6

`define RST_DIVIDE 4'h0
`define RST_OSC_LEVEL 4'h5
`define RST_SEGMENT_LOW 2'h2
`define RST_ENHANCE 5'h16
`define RST_PIN_MODE 2'h2
`define RST_PRECHARGE 4'h8

`define DIV_MAX_CODE 4'hA
`define DIV_FULL 10'h3FF

`define PIN_HIZ_OFF 2'h0
`define PIN_HIZ_IN 2'h1
`define PIN_DRIVE_LOW 2'h2
`define PIN_DRIVE_HIGH 2'h3

`define FLD_DIVIDE 0
`define FLD_OSC_LEVEL 4
`define FLD_SEGMENT_LOW 8
`define FLD_ENHANCE 10
`define FLD_PRECHARGE 16
`define FLD_WAITING 28
`define FLD_PIN_MODE 0
`define FLD_PIN_LEVEL 4

`endif

// file: src/disp_timing_pkg.sv
// Types shared by the timing setup block.
package disp_timing_pkg;

  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_CLOCK_PARAM,
    ST_SEGMENT_PARAM,
    ST_ENHANCE_PARAM,
    ST_PIN_PARAM,
    ST_PRECHARGE_PARAM
  } cmd_state_e;

  typedef logic [7:0] byte_t;

endpackage : disp_timing_pkg

// file: src/display_timing_setup_commands.sv
// Timing setup command decoder with AHB-Lite register port and pin control.
//
// The register addresses and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "disp_timing_consts.svh"

module display_timing_setup_commands
  import disp_timing_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [1:0] general_pin_in,
  output logic [1:0] general_pin_out,
  output logic [1:0] general_pin_oe_n,
  output logic [3:0] clock_divide_setting,
  output logic [3:0] oscillator_level,
  output logic [1:0] segment_low_voltage,
  output logic [4:0] gray_level_enhance,
  output logic [3:0] second_precharge_clocks,
  output logic display_clk_tick
);

  // Bus address phase capture.
  logic wr_pending;
  logic [7:0] wr_addr;

  // Command decoder state.
  cmd_state_e state;
  cmd_state_e next_state;
  cmd_state_e opcode_target;
  cmd_state_e param_follow;

  // Per-pin configuration and synchronised input levels.
  logic [1:0] pin_mode [2];
  logic [1:0] pin_meta;
  logic [1:0] pin_sync;

  // Display clock divider.
  logic [9:0] div_count;

  // Address phase decode.
  wire addr_phase = hsel & htrans[1] & hready;
  wire read_take = addr_phase & ~hwrite;
  wire write_take = addr_phase & hwrite;

  // Data phase decode; hwdata stands at the edge that ends the data phase.
  wire cmd_write = wr_pending & (wr_addr == `OFF_COMMAND);
  wire par_write = wr_pending & (wr_addr == `OFF_PARAMETER);
  wire byte_t in_byte = hwdata[7:0];

  // Parameter bytes land in the field of the command that preceded them.
  wire take_clock = par_write & (state == ST_CLOCK_PARAM);
  wire take_segment = par_write & (state == ST_SEGMENT_PARAM);
  wire take_enhance = par_write & (state == ST_ENHANCE_PARAM);
  wire take_pins = par_write & (state == ST_PIN_PARAM);
  wire take_precharge = par_write & (state == ST_PRECHARGE_PARAM);

  // Read data mux; unmapped addresses read as zero. The word is built
  // from the fields as they stand in the address phase, so a read that
  // directly follows a parameter write still sees the old value.
  wire waiting = (state != ST_OPCODE);
  wire [31:0] divide_part = 32'(clock_divide_setting) << `FLD_DIVIDE;
  wire [31:0] osc_part = 32'(oscillator_level) << `FLD_OSC_LEVEL;
  wire [31:0] segment_part = 32'(segment_low_voltage) << `FLD_SEGMENT_LOW;
  wire [31:0] enhance_part = 32'(gray_level_enhance) << `FLD_ENHANCE;
  wire [31:0] precharge_part =
    32'(second_precharge_clocks) << `FLD_PRECHARGE;
  wire [31:0] waiting_part = 32'(waiting) << `FLD_WAITING;
  wire [31:0] settings_word = divide_part | osc_part | segment_part |
    enhance_part | precharge_part | waiting_part;

  // A pin whose input is disabled reads low.
  wire [1:0] pin_level;
  wire [3:0] both_modes = {pin_mode[1], pin_mode[0]};
  wire [31:0] pin_mode_part = 32'(both_modes) << `FLD_PIN_MODE;
  wire [31:0] pin_level_part = 32'(pin_level) << `FLD_PIN_LEVEL;
  wire [31:0] pins_word = pin_mode_part | pin_level_part;

  wire sel_settings = (haddr == `OFF_SETTINGS);
  wire sel_pins = (haddr == `OFF_PINS);
  wire [31:0] read_word =
    sel_settings ? settings_word :
    sel_pins ? pins_word : 32'h0000_0000;

  // Divide codes above the largest valid one hold at division by 1024.
  wire [3:0] div_code_eff = (clock_divide_setting > `DIV_MAX_CODE) ?
    `DIV_MAX_CODE : clock_divide_setting;
  // Terminal count is two to the code, less one.
  wire [9:0] div_terminal = `DIV_FULL >> (`DIV_MAX_CODE - div_code_eff);
  wire div_wrap = (div_count == div_terminal);

  // Stage that each opcode opens; unknown opcodes leave the decoder idle.
  always_comb begin
    opcode_target = ST_OPCODE;
    unique case (in_byte)
      `OP_CLOCK_SETUP: opcode_target = ST_CLOCK_PARAM;
      `OP_SEGMENT_ENHANCE: opcode_target = ST_SEGMENT_PARAM;
      `OP_PIN_SETUP: opcode_target = ST_PIN_PARAM;
      `OP_PRECHARGE: opcode_target = ST_PRECHARGE_PARAM;
      default: opcode_target = ST_OPCODE;
    endcase
  end

  // Stage that follows a parameter byte; only B4 takes a second one.
  always_comb begin
    param_follow = ST_OPCODE;
    unique case (state)
      ST_OPCODE: param_follow = ST_OPCODE;
      ST_CLOCK_PARAM: param_follow = ST_OPCODE;
      ST_SEGMENT_PARAM: param_follow = ST_ENHANCE_PARAM;
      ST_ENHANCE_PARAM: param_follow = ST_OPCODE;
      ST_PIN_PARAM: param_follow = ST_OPCODE;
      ST_PRECHARGE_PARAM: param_follow = ST_OPCODE;
      default: param_follow = ST_OPCODE;
    endcase
  end

  // A new opcode always wins, so it aborts any parameters still pending.
  always_comb begin
    next_state = state;
    if (cmd_write) begin
      next_state = opcode_target;
    end else if (par_write) begin
      next_state = param_follow;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= ST_OPCODE;
    end else begin
      state <= next_state;
    end
  end

  // Write address capture for the data phase that follows.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pending <= write_take;
      if (write_take) begin
        wr_addr <= haddr;
      end
    end
  end

  // Read data is captured at the end of the address phase and stands
  // until the next read, so the master may take it late in the data phase.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (read_take) begin
      hrdata <= read_word;
    end
  end

  // Bus slave answer: zero wait states, always OKAY.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Divide code; an invalid code is kept as written and clamped later.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clock_divide_setting <= `RST_DIVIDE;
    end else if (take_clock) begin
      clock_divide_setting <= in_byte[3:0];
    end
  end

  // Higher levels run the oscillator faster; the level is only stored
  // here and handed to the analog side as it stands.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      oscillator_level <= `RST_OSC_LEVEL;
    end else if (take_clock) begin
      oscillator_level <= in_byte[7:4];
    end
  end

  // Segment-low voltage source from the first byte of B4.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      segment_low_voltage <= `RST_SEGMENT_LOW;
    end else if (take_segment) begin
      segment_low_voltage <= in_byte[1:0];
    end
  end

  // Enhancement field; bits 2:0 of the second byte carry a fixed pattern
  // and are not stored.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      gray_level_enhance <= `RST_ENHANCE;
    end else if (take_enhance) begin
      gray_level_enhance <= in_byte[7:3];
    end
  end

  // Second pre-charge length in display clocks.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      second_precharge_clocks <= `RST_PRECHARGE;
    end else if (take_precharge) begin
      second_precharge_clocks <= in_byte[3:0];
    end
  end

  // Display clock divider; restarts whenever the clock setup is written so
  // that the first tick after a change already has the new period. The
  // tick is held off on that edge, so the gap before the next tick is
  // never shorter than the new period.
  wire div_restart = take_clock | div_wrap;
  wire [9:0] div_step = div_count + 10'h001;
  wire [9:0] next_div_count = div_restart ? 10'h000 : div_step;
  wire next_tick = div_wrap & ~take_clock;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      div_count <= 10'h000;
    end else begin
      div_count <= next_div_count;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      display_clk_tick <= 1'b0;
    end else begin
      display_clk_tick <= next_tick;
    end
  end

  // General pins: both share one encoding, pin i uses bits 2i+1:2i. The
  // drive and enable flops see the mode of the same edge, so a pin changes
  // together with its field; the input passes two flops before use.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_pin
      wire [1:0] new_mode = in_byte[2*gi +: 2];
      wire [1:0] mode_now = take_pins ? new_mode : pin_mode[gi];
      wire drive_low = (mode_now == `PIN_DRIVE_LOW);
      wire drive_high = (mode_now == `PIN_DRIVE_HIGH);
      wire drives = drive_low | drive_high;
      wire input_on = (pin_mode[gi] == `PIN_HIZ_IN);

      assign pin_level[gi] = pin_sync[gi] & input_on;

      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          pin_mode[gi] <= `RST_PIN_MODE;
        end else if (take_pins) begin
          pin_mode[gi] <= new_mode;
        end
      end

      // Reset leaves both pins driving low, as the reset mode asks.
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          general_pin_out[gi] <= 1'b0;
          general_pin_oe_n[gi] <= 1'b0;
        end else begin
          general_pin_out[gi] <= drive_high;
          general_pin_oe_n[gi] <= ~drives;
        end
      end

      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else begin
          pin_meta[gi] <= general_pin_in[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

endmodule : display_timing_setup_commands

// file: verification/display_timing_props.sv
// Assertions on the timing setup decoder ports.
`timescale 1ns/1ps
module display_timing_props (
  input wire logic core_clk, resetn, hreadyout, hresp, display_clk_tick,
  input wire logic [1:0] general_pin_out, general_pin_oe_n,
  input wire logic [1:0] segment_low_voltage,
  input wire logic [3:0] clock_divide_setting, oscillator_level,
  input wire logic [3:0] second_precharge_clocks,
  input wire logic [4:0] gray_level_enhance
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence released; $rose(resetn); endsequence
  sequence div2_tick; display_clk_tick && clock_divide_setting == 4'h1;
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer");
  chk_reset_clock: assert property (released |->
    clock_divide_setting == 4'h0 && oscillator_level == 4'h5)
    else $error("clock reset");
  chk_reset_analog: assert property (released |->
    segment_low_voltage == 2'h2 && gray_level_enhance == 5'h16 &&
    second_precharge_clocks == 4'h8) else $error("analog reset");
  chk_reset_pins: assert property (released |->
    general_pin_oe_n == 2'h0 && general_pin_out == 2'h0)
    else $error("pin reset");
  chk_tick_every: assert property (
    (clock_divide_setting == 4'h0) [*4] |->
    display_clk_tick || $past(display_clk_tick))
    else $error("tick missing");
  chk_tick_single: assert property (display_clk_tick &&
    clock_divide_setting != 4'h0 ##1 $stable(clock_divide_setting) |->
    !display_clk_tick) else $error("tick too long");
  chk_tick_half: assert property (
    div2_tick ##1 clock_divide_setting == 4'h1 |->
    !display_clk_tick ##1 (display_clk_tick || clock_divide_setting != 4'h1))
    else $error("tick period");
  chk_tick_slowest: assert property (
    display_clk_tick && clock_divide_setting == 4'hA |=>
    (!display_clk_tick || clock_divide_setting != 4'hA) [*8])
    else $error("tick early");
endmodule : display_timing_props

bind display_timing_setup_commands display_timing_props props (.*);

// file: verification/host_model.sv
// Bus master standing in for the host controller.
`timescale 1ns/1ps
module host_model (
  input wire logic core_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic hwrite,
  output logic [7:0] haddr,
  output logic [1:0] htrans,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
  // Opcodes go to offset 0x00 and parameters to 0x04.
  task automatic xfer(input logic w, input logic [7:0] a, d,
    output logic [31:0] q);
    {hsel, hwrite, haddr, htrans, hsize} <= {1'b1, w, a, 5'h12};
    @(posedge core_clk iff hready);
    htrans <= 2'h0;
    hwdata <= {24'hA5_A5A5, d};
    @(posedge core_clk iff hready);
    q = hrdata;
    hwdata <= ~hwdata;
  endtask : xfer
endmodule : host_model

// file: verification/tb_display_timing_setup_commands.sv
// Self-checking bench for the timing setup command decoder.
`timescale 1ns/1ps
module tb_display_timing_setup_commands;
  logic core_clk = 0, resetn = 0, hsel, hwrite, hready, display_clk_tick;
  logic [1:0] htrans, general_pin_in, general_pin_out, general_pin_oe_n;
  logic [1:0] ext = 0, seg = 2;
  logic [2:0] hsize;
  logic [7:0] haddr;
  logic [31:0] hwdata, hrdata, q, r;
  logic [3:0] div = 0, osc = 5, pre = 8, modes = 4'hA;
  logic [4:0] enh = 5'h16;
  integer seed = 32'h60ae_5cc9;
  int fails = 0, tests_run = 0, cycles = 0, n;
  always #12.5 core_clk = ~core_clk;
  assign general_pin_in = general_pin_out & ~general_pin_oe_n |
    ext & general_pin_oe_n;
  display_timing_setup_commands DUT (.*, .hreadyout(hready), .hresp(),
    .clock_divide_setting(), .oscillator_level(), .segment_low_voltage(),
    .gray_level_enhance(), .second_precharge_clocks());
  host_model host (.*);
  function automatic logic [31:0] settings_exp();
    return {12'h0, pre, 1'b0, enh, seg, osc, div};
  endfunction : settings_exp
  function automatic logic [31:0] pins_exp();
    return {26'h0, modes[3:2] == 2'h1 && ext[1],
      modes[1:0] == 2'h1 && ext[0], modes};
  endfunction : pins_exp
  task automatic chk(input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %h not %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1;
    @(posedge core_clk);
    host.xfer(1, 8'h04, 8'h37, q);
    host.xfer(0, 8'h10, 0, q);
    chk(q, 0);
    repeat (41) begin
      host.xfer(0, 8'h08, 0, q);
      chk(q, settings_exp());
      host.xfer(0, 8'h0C, 0, q);
      chk(q, pins_exp());
      chk({general_pin_oe_n, general_pin_out & ~general_pin_oe_n},
        {~modes[3], ~modes[1], modes[3] & modes[2], modes[1] & modes[0]});
      r = $random(seed);
      ext <= r[20:19];
      // An opcode cut short by the next one must leave no trace.
      if (r[16]) host.xfer(1, 8'h00, 8'hB3 + r[18:17], q);
      host.xfer(1, 8'h00, 8'hB3 + r[5:4], q);
      case (r[5:4])
        2'h0: {osc, div} = {r[11:8], 4'(r[3:0] % 11)};
        2'h1: {seg, enh} = {r[6], 1'b0, r[7] ? 5'h1F : 5'h16};
        2'h2: modes = r[11:8];
        default: pre = r[11:8];
      endcase
      if (r[5:4] == 2'h1) begin
        host.xfer(1, 8'h04, {6'h0, seg}, q);
        host.xfer(1, 8'h04, {enh, 3'b101}, q);
      end else begin
        host.xfer(1, 8'h04, r[5:4] ? r[15:8] : {osc, div}, q);
      end
      host.xfer(1, 8'h04, r[31:24], q);
    end
    for (int k = 0; k < 11; k++) begin
      div = 4'(k);
      host.xfer(1, 8'h00, 8'hB3, q);
      host.xfer(1, 8'h04, {osc, div}, q);
      repeat (2) @(posedge core_clk iff display_clk_tick);
      @(posedge core_clk);
      for (n = 1; !display_clk_tick && n < 2000; n++) @(posedge core_clk);
      chk(n, 32'h1 << div);
    end
    wrap_up();
  end
endmodule : tb_display_timing_setup_commands
